// ===== core/mis_pkg.sv
// Constants and types shared by the maskable interrupt sequencer.
package mis_pkg;
  localparam int          MIS_N_MASK       = 13;
  localparam logic [7:0]  MIS_OFS_PEND     = 8'h00;
  localparam logic [7:0]  MIS_OFS_ENA      = 8'h04;
  localparam logic [7:0]  MIS_OFS_STAT     = 8'h08;
  localparam logic [7:0]  MIS_OFS_VEC      = 8'h0C;
  localparam logic [12:0] MIS_PEND_RST     = 13'h0000;
  localparam logic [12:0] MIS_ENA_RST      = 13'h0000;
  localparam int          MIS_STAT_GIE     = 0;
  localparam int          MIS_STAT_TRAP    = 1;
  localparam int          MIS_STAT_ACK     = 2;
  localparam logic [2:0]  MIS_ACK_CYCLES   = 3'h7;
  localparam logic [2:0]  MIS_PUSH_CYCLE   = 3'h1;
  localparam logic [14:0] MIS_SERVICE_ADDR = 15'h00FF;
  localparam logic [3:0]  MIS_SLOT_TRAP    = 4'hF;
  localparam logic [3:0]  MIS_SLOT_TOPMASK = 4'hD;
  localparam logic [3:0]  MIS_SLOT_DEFAULT = 4'h0;
  localparam logic [1:0]  MIS_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  MIS_RESP_DECERR  = 2'h3;
  typedef enum {MIS_IDLE, MIS_ACK} mis_state_t;
endpackage

// ===== core/mis_sequencer.sv
// Interrupt pending, enable, arbitration and acknowledge sequencer with an AXI4-Lite register slave.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Software trap wins over all requests; default vector slot ranks lowest.
// - Each maskable source has a fixed rank and vector slot.
// - All sources but the trap are maskable, each with enable and pending bit.
// - A source event sets its pending bit regardless of enables.
// - Pending, enable and global enable bits are software readable and writable.
// - Maskable request fires only with enable, global enable, and no non-maskable service.
// - Requests are judged at instruction start; highest rank served, others stay pending.
// - Reset clears all pending bits, enables and the global enable.
// - Enabling a source whose pending bit is set triggers it at once.
// - Acknowledge only at a normally executed instruction start, after any skip.
// - Acknowledge clears the global enable first.
// - Acknowledge pushes the address of the next instruction.
// - Acknowledge loads the program counter with the common service address.
// - Acknowledge takes exactly seven instruction cycles.
// - Return sets global enable, pops the return address, then serves pending requests.
// - Boot ROM execution blocks interrupts but keeps the global enable.
// - Repeated events of an already pending source are not counted.
module mis_sequencer
  import mis_pkg::*;
#(
  parameter int N_MASK = mis_pkg::MIS_N_MASK
) (
  input  wire logic              CLOCK_IN,
  input  wire logic              NRST_IN,
  input  wire logic [7:0]        AWADDR_IN,
  input  wire logic              AWVALID_IN,
  output logic                   AWREADY_OUT,
  input  wire logic [31:0]       WDATA_IN,
  input  wire logic [3:0]        WSTRB_IN,
  input  wire logic              WVALID_IN,
  output logic                   WREADY_OUT,
  output logic [1:0]             BRESP_OUT,
  output logic                   BVALID_OUT,
  input  wire logic              BREADY_IN,
  input  wire logic [7:0]        ARADDR_IN,
  input  wire logic              ARVALID_IN,
  output logic                   ARREADY_OUT,
  output logic [31:0]            RDATA_OUT,
  output logic [1:0]             RRESP_OUT,
  output logic                   RVALID_OUT,
  input  wire logic              RREADY_IN,
  input  wire logic [N_MASK-1:0] SRC_EVENT_IN,
  input  wire logic              TRAP_IN,
  input  wire logic              INSTR_TICK_IN,
  input  wire logic              INSTR_START_IN,
  input  wire logic              SKIP_PENDING_IN,
  input  wire logic [14:0]       NEXT_PC_IN,
  input  wire logic              RETURN_FROM_IRQ_INSTRUCTION_IN,
  input  wire logic              NMI_BUSY_IN,
  input  wire logic              BOOT_ROM_IN,
  output logic                   ACK_BUSY_OUT,
  output logic                   PUSH_STB_OUT,
  output logic [14:0]            PUSH_ADDR_OUT,
  output logic                   PC_LOAD_OUT,
  output logic [14:0]            PC_VALUE_OUT,
  output logic                   POP_STB_OUT,
  output logic [3:0]             VECTOR_SLOT_OUT
);
  import mis_pkg::*;

  // ==========================================================
  // State
  mis_state_t        state_r, state_nxt;
  logic [N_MASK-1:0] pend_r, pend_nxt, ena_r, ena_nxt, active;
  logic              gie_r, gie_nxt, trap_r, trap_nxt;
  logic [2:0]        cnt_r, cnt_nxt;
  logic [3:0]        vec_r, vec_nxt, best_slot;
  logic [14:0]       ret_r, ret_nxt;
  logic              push_r, push_nxt, load_r, load_nxt, pop_r, pop_nxt;
  logic              aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]        aw_addr_r, aw_addr_nxt;
  logic [31:0]       w_data_r, w_data_nxt, wmask, wval;
  logic [3:0]        w_strb_r, w_strb_nxt;
  logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt, rd_word;
  logic              wr_en, qual_mask, qual_trap, take;

  // ==========================================================
  // Arbitration
  assign active    = pend_r & ena_r;
  assign qual_trap = trap_r && !BOOT_ROM_IN;
  assign qual_mask = gie_r && !NMI_BUSY_IN && !BOOT_ROM_IN && (|active);
  assign take      = (state_r == MIS_IDLE) && INSTR_START_IN && !SKIP_PENDING_IN
                     && (qual_trap || qual_mask);
  assign wr_en     = aw_got_r && w_got_r && !bvalid_r;

  // Index 0 is the highest ranked maskable source; ranks are hard wired.
  always_comb begin
    best_slot = MIS_SLOT_DEFAULT;
    for (int i = N_MASK - 1; i >= 0; i--) begin
      if (active[i]) begin
        best_slot = MIS_SLOT_TOPMASK - 4'(i);
      end
    end
    if (trap_r) begin
      best_slot = MIS_SLOT_TRAP;
    end
  end

  always_comb begin
    wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wval  = 32'h0000_0000;
    unique case (aw_addr_r)
      MIS_OFS_PEND: wval = 32'(pend_r);
      MIS_OFS_ENA:  wval = 32'(ena_r);
      MIS_OFS_STAT: wval = {31'h0000_0000, gie_r};
      default:      wval = 32'h0000_0000;
    endcase
    wval = (wval & ~wmask) | (w_data_r & wmask);
  end

  always_comb begin
    unique case (ARADDR_IN)
      MIS_OFS_PEND: rd_word = 32'(pend_r);
      MIS_OFS_ENA:  rd_word = 32'(ena_r);
      MIS_OFS_STAT: rd_word = 32'({state_r == MIS_ACK, trap_r, gie_r});
      MIS_OFS_VEC:  rd_word = 32'({vec_r, best_slot});
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt  = state_r;
    pend_nxt   = pend_r;
    ena_nxt    = ena_r;
    gie_nxt    = gie_r;
    trap_nxt   = trap_r;
    cnt_nxt    = cnt_r;
    vec_nxt    = vec_r;
    ret_nxt    = ret_r;
    push_nxt   = 1'b0;
    load_nxt   = 1'b0;
    pop_nxt    = 1'b0;
    aw_got_nxt = aw_got_r;
    aw_addr_nxt = aw_addr_r;
    w_got_nxt  = w_got_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r && !BREADY_IN;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r && !RREADY_IN;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (AWVALID_IN && AWREADY_OUT) begin
      aw_got_nxt  = 1'b1;
      aw_addr_nxt = AWADDR_IN;
    end
    if (WVALID_IN && WREADY_OUT) begin
      w_got_nxt  = 1'b1;
      w_data_nxt = WDATA_IN;
      w_strb_nxt = WSTRB_IN;
    end
    if (wr_en) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = MIS_RESP_OKAY;
      unique case (aw_addr_r)
        MIS_OFS_PEND: pend_nxt = wval[N_MASK-1:0];
        MIS_OFS_ENA:  ena_nxt = wval[N_MASK-1:0];
        MIS_OFS_STAT: gie_nxt = wval[MIS_STAT_GIE];
        MIS_OFS_VEC:  bresp_nxt = MIS_RESP_OKAY;
        default:      bresp_nxt = MIS_RESP_DECERR;
      endcase
    end
    if (ARVALID_IN && ARREADY_OUT) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = (ARADDR_IN <= MIS_OFS_VEC && ARADDR_IN[1:0] == 2'h0) ? MIS_RESP_OKAY : MIS_RESP_DECERR;
    end
    if (RETURN_FROM_IRQ_INSTRUCTION_IN) begin
      gie_nxt = 1'b1;
      pop_nxt = 1'b1;
    end
    unique case (state_r)
      MIS_IDLE: begin
        if (take) begin
          state_nxt = MIS_ACK;
          gie_nxt   = 1'b0;
          cnt_nxt   = 3'h1;
          vec_nxt   = best_slot;
          ret_nxt   = NEXT_PC_IN;
          if (qual_trap) begin
            trap_nxt = 1'b0;
          end
        end
      end
      MIS_ACK: begin
        if (INSTR_TICK_IN) begin
          cnt_nxt  = cnt_r + 3'h1;
          push_nxt = (cnt_r == MIS_PUSH_CYCLE);
          if (cnt_r == MIS_ACK_CYCLES - 3'h1) begin
            load_nxt  = 1'b1;
            state_nxt = MIS_IDLE;
          end
        end
      end
    endcase
    pend_nxt = pend_nxt | SRC_EVENT_IN;
    trap_nxt = trap_nxt | TRAP_IN;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_r   <= MIS_IDLE;
      pend_r    <= MIS_PEND_RST;
      ena_r     <= MIS_ENA_RST;
      gie_r     <= 1'b0;
      trap_r    <= 1'b0;
      cnt_r     <= 3'h0;
      vec_r     <= MIS_SLOT_DEFAULT;
      ret_r     <= 15'h0000;
      push_r    <= 1'b0;
      load_r    <= 1'b0;
      pop_r     <= 1'b0;
      aw_got_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_got_r   <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= MIS_RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= MIS_RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      state_r   <= state_nxt;
      pend_r    <= pend_nxt;
      ena_r     <= ena_nxt;
      gie_r     <= gie_nxt;
      trap_r    <= trap_nxt;
      cnt_r     <= cnt_nxt;
      vec_r     <= vec_nxt;
      ret_r     <= ret_nxt;
      push_r    <= push_nxt;
      load_r    <= load_nxt;
      pop_r     <= pop_nxt;
      aw_got_r  <= aw_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_got_r   <= w_got_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign AWREADY_OUT     = !aw_got_r && !bvalid_r;
  assign WREADY_OUT      = !w_got_r && !bvalid_r;
  assign BVALID_OUT      = bvalid_r;
  assign BRESP_OUT       = bresp_r;
  assign ARREADY_OUT     = !rvalid_r;
  assign RVALID_OUT      = rvalid_r;
  assign RDATA_OUT       = rdata_r;
  assign RRESP_OUT       = rresp_r;
  assign ACK_BUSY_OUT    = (state_r == MIS_ACK);
  assign PUSH_STB_OUT    = push_r;
  assign PUSH_ADDR_OUT   = ret_r;
  assign PC_LOAD_OUT     = load_r;
  assign PC_VALUE_OUT    = MIS_SERVICE_ADDR;
  assign POP_STB_OUT     = pop_r;
  assign VECTOR_SLOT_OUT = vec_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);

  chk_trap_first: assert property (take && trap_r |=> vec_r == MIS_SLOT_TRAP)
    else $error("Trap did not win arbitration.");
  chk_rank_top: assert property (take && !trap_r && active[0] |=> vec_r == MIS_SLOT_TOPMASK)
    else $error("Top ranked source not served first.");
  chk_event_sets: assert property ((SRC_EVENT_IN != '0) |=> ((pend_r & $past(SRC_EVENT_IN)) == $past(SRC_EVENT_IN)))
    else $error("Source event did not leave its pending bit set.");
  chk_gie_gate: assert property (state_r == MIS_IDLE && INSTR_START_IN && !gie_r && !trap_r |=> state_r == MIS_IDLE)
    else $error("Maskable request taken without global enable.");
  chk_skip_first: assert property (state_r == MIS_IDLE && SKIP_PENDING_IN |=> state_r == MIS_IDLE)
    else $error("Acknowledge started before a pending skip.");
  chk_gie_cleared: assert property (take |=> !gie_r && ACK_BUSY_OUT && PUSH_ADDR_OUT == $past(NEXT_PC_IN))
    else $error("Acknowledge start did not clear enable or save return address.");
  chk_seven_cycles: assert property (ACK_BUSY_OUT && INSTR_TICK_IN && cnt_r == 3'h6
                                     |=> PC_LOAD_OUT && !ACK_BUSY_OUT && PC_VALUE_OUT == 15'h00FF)
    else $error("Service address not loaded at seventh instruction cycle.");
  chk_push_once: assert property (ACK_BUSY_OUT && INSTR_TICK_IN && cnt_r == 3'h1 |=> PUSH_STB_OUT ##1 !PUSH_STB_OUT)
    else $error("Return address push missing or repeated.");
  chk_return_from_irq_instruction_gie: assert property (RETURN_FROM_IRQ_INSTRUCTION_IN && !wr_en && !take && state_r == MIS_IDLE |=> gie_r && POP_STB_OUT)
    else $error("Return did not restore enable and pop.");
  chk_boot_block: assert property (BOOT_ROM_IN && !wr_en && !RETURN_FROM_IRQ_INSTRUCTION_IN && state_r == MIS_IDLE
                                   |=> state_r == MIS_IDLE && gie_r == $past(gie_r))
    else $error("Interrupt taken or enable changed in boot ROM.");
  chk_reset_zero: assert property ($rose(NRST_IN) |-> pend_r == '0 && ena_r == '0 && !gie_r)
    else $error("Reset left interrupt state set.");
endmodule

// ===== sim/mis_core_model.sv
// Core sequencer model that paces instruction cycles and follows program counter loads.
`timescale 1ns/1ps
module mis_core_model (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        busy_in,
  input  wire logic        load_in,
  input  wire logic [14:0] value_in,
  output logic             tick_out,
  output logic             start_out,
  output logic [14:0]      pc_out
);
  logic [1:0] div_r;
  // No instruction starts while the acknowledge sequence owns the core.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {div_r, tick_out, start_out} <= '0;
      pc_out <= 15'h0100;
    end else begin
      div_r <= div_r + 2'h1;
      tick_out <= (div_r == 2'h3);
      start_out <= (div_r == 2'h3) && !busy_in;
      pc_out <= load_in ? value_in : pc_out + {14'h0000, start_out};
    end
  end
endmodule

// ===== sim/test_maskable_interrupt_sequencer.sv
// Self-checking bench for the interrupt sequencer driven by a core model.
`timescale 1ns/1ps
module test_maskable_interrupt_sequencer;
  import mis_pkg::*;
  logic        clk, rst_n, awv, wv, arv, trap, return_from_irq_instruction, nmi, boot, skip;
  logic        aw_r, w_r, bv, ar_r, rv, tick, start, busy, push, pcl, pop;
  logic [1:0]  br, rr;
  logic [3:0]  slot;
  logic [7:0]  awa, ara;
  logic [12:0] ev;
  logic [14:0] npc, paddr, pcv, last_pc;
  logic [31:0] wd, rdat;
  int          n_mismatch, total_checks, cyc;

  mis_sequencer uut (.CLOCK_IN(clk), .NRST_IN(rst_n), .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(aw_r),
    .WDATA_IN(wd), .WSTRB_IN(4'hF), .WVALID_IN(wv), .WREADY_OUT(w_r), .BRESP_OUT(br), .BVALID_OUT(bv),
    .BREADY_IN(1'b1), .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(ar_r), .RDATA_OUT(rdat),
    .RRESP_OUT(rr), .RVALID_OUT(rv), .RREADY_IN(1'b1), .SRC_EVENT_IN(ev), .TRAP_IN(trap),
    .INSTR_TICK_IN(tick), .INSTR_START_IN(start), .SKIP_PENDING_IN(skip), .NEXT_PC_IN(npc), .RETURN_FROM_IRQ_INSTRUCTION_IN(return_from_irq_instruction),
    .NMI_BUSY_IN(nmi), .BOOT_ROM_IN(boot), .ACK_BUSY_OUT(busy), .PUSH_STB_OUT(push), .PUSH_ADDR_OUT(paddr),
    .PC_LOAD_OUT(pcl), .PC_VALUE_OUT(pcv), .POP_STB_OUT(pop), .VECTOR_SLOT_OUT(slot));
  mis_core_model core (.clk_in(clk), .nrst_in(rst_n), .busy_in(busy), .load_in(pcl), .value_in(pcv),
    .tick_out(tick), .start_out(start), .pc_out(npc));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Remembers the address offered at the last accepted instruction start.
  always @(posedge clk) begin
    cyc++;
    if (start === 1'b1 && busy === 1'b0) last_pc <= npc;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Bus tasks wait for the answer without a cycle limit; only the bench timeout ends a hang.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_r === 1'b1) awv <= 1'b0;
      if (w_r === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    chk("bresp", MIS_RESP_OKAY, br);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_r === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    chk("read", {er, e}, {rr, rdat});
  endtask
  task automatic quiet();
    logic bad = 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (busy !== 1'b0) bad = 1'b1;
    end
    chk("no_ack", 0, bad);
  endtask
  task automatic retire();
    @(posedge clk);
    return_from_irq_instruction <= 1'b1;
    @(posedge clk);
    return_from_irq_instruction <= 1'b0;
    @(posedge clk);
    chk("pop_stb", 1, pop);
  endtask
  task automatic ack(input logic [3:0] s);
    int n = 0;
    int t = 0;
    int np = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    while (busy === 1'b1 && n < 200) begin
      if (tick === 1'b1) t++;
      if (push === 1'b1) np++;
      if (push === 1'b1) chk("push_addr", last_pc, paddr);
      @(posedge clk);
      n++;
    end
    chk("ack_ticks", 6, t);
    chk("push_count", 1, np);
    chk("pc_load", 1, pcl);
    chk("pc_value", MIS_SERVICE_ADDR, pcv);
    chk("slot", s, slot);
  endtask

  initial begin
    {rst_n, awv, wv, arv, trap, return_from_irq_instruction, nmi, boot, skip, awa, ara, ev, wd} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(MIS_OFS_PEND, 32'h0, MIS_RESP_OKAY);
    rd(MIS_OFS_ENA, 32'h0, MIS_RESP_OKAY);
    rd(MIS_OFS_STAT, 32'h0, MIS_RESP_OKAY);
    rd(8'h10, 32'h0, MIS_RESP_DECERR);
    ev <= 13'h0020;
    @(posedge clk);
    ev <= 13'h0000;
    rd(MIS_OFS_PEND, 32'h20, MIS_RESP_OKAY);
    wr(MIS_OFS_STAT, 32'h1);
    quiet();
    wr(MIS_OFS_ENA, 32'h224);
    ack(4'h8);
    rd(MIS_OFS_STAT, 32'h0, MIS_RESP_OKAY);
    rd(MIS_OFS_ENA, 32'h224, MIS_RESP_OKAY);
    $display("reset and enable test done");
    nmi <= 1'b1;
    retire();
    quiet();
    rd(MIS_OFS_STAT, 32'h1, MIS_RESP_OKAY);
    trap <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    ack(MIS_SLOT_TRAP);
    nmi <= 1'b0;
    ev <= 13'h0204;
    @(posedge clk);
    ev <= 13'h0000;
    rd(MIS_OFS_PEND, 32'h224, MIS_RESP_OKAY);
    retire();
    ack(4'hB);
    wr(MIS_OFS_PEND, 32'h220);
    retire();
    ack(4'h8);
    $display("priority test done");
    ev <= 13'h0200;
    wr(MIS_OFS_PEND, 32'h0);
    ev <= 13'h0000;
    rd(MIS_OFS_PEND, 32'h200, MIS_RESP_OKAY);
    boot <= 1'b1;
    retire();
    quiet();
    rd(MIS_OFS_STAT, 32'h1, MIS_RESP_OKAY);
    boot <= 1'b0;
    ack(4'h4);
    skip <= 1'b1;
    retire();
    quiet();
    skip <= 1'b0;
    ack(4'h4);
    $display("blocking test done");
    wr(MIS_OFS_STAT, 32'h1);
    ack(4'h4);
    wr(MIS_OFS_ENA, 32'h1225);
    ev <= 13'h0001;
    @(posedge clk);
    ev <= 13'h0000;
    retire();
    ack(MIS_SLOT_TOPMASK);
    rd(MIS_OFS_VEC, 32'hDD, MIS_RESP_OKAY);
    $display("nesting and rank test done");
    conclude();
  end
endmodule
